// ===== logic/reset_status_and_delay_sequencer.sv
// The address map and the APB slave port were chosen for this implementation.
`timescale 1ns/10ps
module reset_status_and_delay_sequencer #(
  parameter int POWERUP_TIMER_CYCLES = rst_seq_pkg::TPWRT_CYC
) (
  input wire logic pclk, // APB clock, 40 MHz
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [3:0] pstrb, // APB byte strobes
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic por_req, // Power-on reset pulse
  input wire logic bor_req, // Brown-out reset pulse
  input wire logic pin_master_clear_n, // Master-clear pin, async
  input wire logic soft_reset_req, // Reset instruction pulse
  input wire logic wdog_timeout, // Watchdog time-out pulse
  input wire logic trap_conflict, // Trap conflict pulse
  input wire logic illegal_op, // Illegal opcode/mode/W pulse
  input wire logic power_save_sleep, // Sleep instruction pulse
  input wire logic power_save_idle, // Idle instruction pulse
  input wire logic wake_req, // Wake from Sleep pulse
  input wire logic regulator_en, // On-chip regulator enabled
  input wire logic clock_switch_en, // Clock switching enabled
  input wire logic [2:0] config_osc_select, // Configured source
  input wire logic [2:0] current_osc_select, // Current source
  input wire logic primary_is_crystal, // Primary source is a crystal
  input wire logic wdog_fuse_enable, // Watchdog fuse enable
  input wire logic clock_fail_monitor_en, // Clock monitor enabled
  input wire logic osc_tick, // Oscillator period, async
  input wire logic pll_lock, // PLL lock, async
  input wire logic osc_valid, // Clock present, async
  output logic system_reset_n, // System reset, active low
  output logic [2:0] osc_select, // Applied clock source
  output logic clock_released, // Valid clock given to system
  output logic cpu_run, // Code execution allowed
  output logic monitor_active, // Clock monitor watching
  output logic clock_fail_trap, // Clock-fail trap pulse
  output logic wdog_enable, // Watchdog enable
  output logic regulator_sleep_keep // Regulator stays on in Sleep
);

  // Synchroniser for the asynchronous inputs
  logic [3:0] async_in;
  logic [3:0] sync1_r;
  logic [3:0] sync2_r;
  logic [3:0] sync3_r;
  logic [3:0] filt_r;
  logic tick_prev_r;
  logic pin_low;
  logic tick_rise;
  logic lock_ok;
  logic clk_ok_in;

  assign async_in = {osc_valid, pll_lock, osc_tick, ~pin_master_clear_n};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_r <= 4'h0;
      sync2_r <= 4'h0;
      sync3_r <= 4'h0;
    end else begin
      sync1_r <= async_in;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  // A bit changes once the second and third stages agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filt_r <= 4'h0;
      tick_prev_r <= 1'b0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (sync2_r[i] == sync3_r[i]) begin
          filt_r[i] <= sync3_r[i];
        end
      end
      tick_prev_r <= filt_r[1];
    end
  end

  assign pin_low = filt_r[0];
  assign tick_rise = filt_r[1] & ~tick_prev_r;
  assign lock_ok = filt_r[2];
  assign clk_ok_in = filt_r[3];

  // Reset event classification; start-up counts as power-on
  logic start_r;
  logic por_evt;
  logic bor_evt;
  logic pin_evt;
  logic oth_evt;
  logic any_evt;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_r <= 1'b1;
    end else begin
      start_r <= 1'b0;
    end
  end

  assign por_evt = por_req | start_r;
  assign bor_evt = bor_req;
  assign pin_evt = pin_low;
  assign oth_evt = soft_reset_req | wdog_timeout | trap_conflict | illegal_op;
  assign any_evt = por_evt | bor_evt | pin_evt | oth_evt;

  // APB decode
  logic wr_en;
  logic rd_sel_status;
  logic rd_sel_seq;
  logic [15:0] status_r;
  logic [15:0] status_nxt;
  logic [15:0] wmask;
  logic [15:0] hw_set;
  logic [15:0] hw_clr;

  assign pready = 1'b1;
  assign wr_en = psel & penable & pwrite & (paddr == rst_seq_pkg::OFF_STATUS);
  assign rd_sel_status = (paddr == rst_seq_pkg::OFF_STATUS);
  assign rd_sel_seq = (paddr == rst_seq_pkg::OFF_SEQ);
  assign wmask = {{8{pstrb[1]}}, {8{pstrb[0]}}} & rst_seq_pkg::STATUS_IMPL;

  // Hardware clear events per flag
  always_comb begin
    hw_clr = 16'h0000;
    if (por_evt) begin
      hw_clr = ~(16'h0001 << rst_seq_pkg::B_POR);
      hw_clr[rst_seq_pkg::B_VREG] = 1'b0;
      hw_clr[rst_seq_pkg::B_WDEN] = 1'b0;
    end
    if (bor_evt) begin
      hw_clr[rst_seq_pkg::B_TRAP] = 1'b1;
      hw_clr[rst_seq_pkg::B_ILLOP] = 1'b1;
      hw_clr[rst_seq_pkg::B_SOFT] = 1'b1;
      hw_clr[rst_seq_pkg::B_WDOG_TIMEOUT_FLAG] = 1'b1;
      hw_clr[rst_seq_pkg::B_SLEEP] = 1'b1;
      hw_clr[rst_seq_pkg::B_IDLE] = 1'b1;
    end
    if (power_save_sleep | power_save_idle) begin
      hw_clr[rst_seq_pkg::B_WDOG_TIMEOUT_FLAG] = 1'b1;
    end
  end

  // Hardware set events per flag
  always_comb begin
    hw_set = 16'h0000;
    hw_set[rst_seq_pkg::B_TRAP] = trap_conflict;
    hw_set[rst_seq_pkg::B_ILLOP] = illegal_op;
    hw_set[rst_seq_pkg::B_PIN] = pin_evt;
    hw_set[rst_seq_pkg::B_SOFT] = soft_reset_req;
    hw_set[rst_seq_pkg::B_WDOG_TIMEOUT_FLAG] = wdog_timeout;
    hw_set[rst_seq_pkg::B_SLEEP] = power_save_sleep;
    hw_set[rst_seq_pkg::B_IDLE] = power_save_idle;
    hw_set[rst_seq_pkg::B_BOR] = bor_evt | por_evt;
    hw_set[rst_seq_pkg::B_POR] = por_evt;
  end

  // Software write, then hardware clear, then hardware set wins
  always_comb begin
    status_nxt = status_r;
    if (wr_en) begin
      status_nxt = (status_r & ~wmask) | (pwdata[15:0] & wmask);
    end
    status_nxt = (status_nxt & ~hw_clr) | hw_set;
    status_nxt = status_nxt & rst_seq_pkg::STATUS_IMPL;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_r <= rst_seq_pkg::STATUS_RST;
    end else begin
      status_r <= status_nxt;
    end
  end

  assign wdog_enable = wdog_fuse_enable | status_r[rst_seq_pkg::B_WDEN];
  assign regulator_sleep_keep = status_r[rst_seq_pkg::B_VREG];

  // Clock source taken at each reset event
  logic [2:0] osc_sel_r;
  logic frc_fallback_r;
  logic is_crystal;
  logic is_pll;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_sel_r <= rst_seq_pkg::OSC_FRC;
    end else if (any_evt) begin
      if (!clock_switch_en || por_evt || bor_evt) begin
        osc_sel_r <= config_osc_select;
      end else begin
        osc_sel_r <= current_osc_select;
      end
    end
  end

  assign is_crystal = ((osc_sel_r == rst_seq_pkg::OSC_PRI) && primary_is_crystal) ||
                      ((osc_sel_r == rst_seq_pkg::OSC_PRIPLL) && primary_is_crystal) ||
                      (osc_sel_r == rst_seq_pkg::OSC_SOSC);
  assign is_pll = (osc_sel_r == rst_seq_pkg::OSC_FRCPLL) ||
                  (osc_sel_r == rst_seq_pkg::OSC_PRIPLL);
  assign osc_select = frc_fallback_r ? rst_seq_pkg::OSC_FRC : osc_sel_r;

  // Reset hold length by reset type
  logic [rst_seq_pkg::DLY_W-1:0] start_cyc;
  logic [rst_seq_pkg::DLY_W-1:0] hold_load;

  always_comb begin
    if (regulator_en) begin
      start_cyc = rst_seq_pkg::DLY_W'(rst_seq_pkg::TSTART_REG_CYC);
    end else begin
      start_cyc = rst_seq_pkg::DLY_W'(POWERUP_TIMER_CYCLES);
    end
    if (por_evt) begin
      hold_load = rst_seq_pkg::DLY_W'(rst_seq_pkg::POWERON_DELAY_CYC + rst_seq_pkg::TRST_CYC)
                  + start_cyc;
    end else if (bor_evt) begin
      hold_load = rst_seq_pkg::DLY_W'(rst_seq_pkg::TRST_CYC) + start_cyc;
    end else begin
      hold_load = rst_seq_pkg::DLY_W'(rst_seq_pkg::TRST_CYC);
    end
  end

  // Sequencer state and delay counter
  rst_seq_pkg::seq_state_t state_r;
  logic [rst_seq_pkg::DLY_W-1:0] dly_r;
  logic clk_ok;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= rst_seq_pkg::S_HOLD;
      dly_r <= '0;
    end else if (any_evt) begin
      state_r <= rst_seq_pkg::S_HOLD;
      dly_r <= hold_load;
    end else begin
      case (state_r)
        rst_seq_pkg::S_HOLD: begin
          if (dly_r <= rst_seq_pkg::DLY_W'(1)) begin
            state_r <= rst_seq_pkg::S_CLKWAIT;
            dly_r <= '0;
          end else begin
            dly_r <= dly_r - rst_seq_pkg::DLY_W'(1);
          end
        end
        rst_seq_pkg::S_CLKWAIT: begin
          if (clk_ok || frc_fallback_r) begin
            state_r <= rst_seq_pkg::S_RUN;
          end
        end
        rst_seq_pkg::S_RUN: begin
          if (wake_req && regulator_en) begin
            state_r <= rst_seq_pkg::S_WAKE;
            dly_r <= start_cyc;
          end
        end
        rst_seq_pkg::S_WAKE: begin
          if (dly_r <= rst_seq_pkg::DLY_W'(1)) begin
            state_r <= rst_seq_pkg::S_RUN;
            dly_r <= '0;
          end else begin
            dly_r <= dly_r - rst_seq_pkg::DLY_W'(1);
          end
        end
        default: begin
          state_r <= rst_seq_pkg::S_HOLD;
          dly_r <= '0;
        end
      endcase
    end
  end

  assign system_reset_n = (state_r != rst_seq_pkg::S_HOLD);

  // Oscillator start-up and PLL lock, running beside the reset hold
  logic [10:0] ost_r;
  logic ost_done;
  logic [11:0] lock_r;
  logic pll_done;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ost_r <= 11'h000;
    end else if (any_evt) begin
      ost_r <= 11'h000;
    end else if (tick_rise && !ost_done) begin
      ost_r <= ost_r + 11'h001;
    end
  end

  assign ost_done = !is_crystal || (ost_r == 11'(rst_seq_pkg::OST_PERIODS));

  // Lock wait starts once the crystal has started
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_r <= 12'h000;
    end else if (any_evt) begin
      lock_r <= 12'h000;
    end else if (is_pll && ost_done && lock_ok && !pll_done) begin
      lock_r <= lock_r + 12'h001;
    end
  end

  assign pll_done = !is_pll || (lock_r == 12'(rst_seq_pkg::TLOCK_CYC));
  assign clk_ok = ost_done && pll_done;
  assign clock_released = clk_ok || frc_fallback_r;
  assign cpu_run = (state_r == rst_seq_pkg::S_RUN);

  // Clock monitor start after reset release
  logic [11:0] mon_r;
  logic mon_on_r;
  logic mon_start;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mon_r <= 12'h000;
      mon_on_r <= 1'b0;
    end else if (any_evt || !system_reset_n) begin
      mon_r <= 12'h000;
      mon_on_r <= 1'b0;
    end else if (mon_start) begin
      mon_on_r <= 1'b1;
    end else if (!mon_on_r) begin
      mon_r <= mon_r + 12'h001;
    end
  end

  assign mon_start = system_reset_n && !mon_on_r && (!(is_crystal || is_pll) ||
                     (mon_r == 12'(rst_seq_pkg::MONITOR_START_DELAY_CYC - 1)));
  assign monitor_active = mon_on_r & clock_fail_monitor_en;

  // Fallback to fast RC and one-cycle trap when no clock at monitor start
  logic trap_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frc_fallback_r <= 1'b0;
      trap_r <= 1'b0;
    end else if (any_evt) begin
      frc_fallback_r <= 1'b0;
      trap_r <= 1'b0;
    end else begin
      trap_r <= 1'b0;
      if (mon_start && clock_fail_monitor_en && !clk_ok_in) begin
        frc_fallback_r <= 1'b1;
        trap_r <= 1'b1;
      end
    end
  end

  assign clock_fail_trap = trap_r;

  // Read data and error answer
  always_comb begin
    prdata = 32'h0000_0000;
    pslverr = 1'b0;
    if (psel && penable) begin
      if (rd_sel_status) begin
        prdata = {16'h0000, status_r};
      end else if (rd_sel_seq) begin
        prdata = {22'h0, frc_fallback_r, monitor_active, clock_released,
                  osc_select, state_r};
      end else begin
        pslverr = 1'b1;
      end
    end
  end

endmodule

// ===== logic/rst_seq_pkg.sv
package rst_seq_pkg;
  // Timing, clock rate and derived cycle counts
  localparam int CLK_PERIOD_NS = 25;
  localparam int POWERON_DELAY_US = 10;
  localparam int TSTART_REG_US = 20;
  localparam int TPWRT_MS = 64;
  localparam int TRST_US = 20;
  localparam int TLOCK_US = 20;
  localparam int MONITOR_START_DELAY_US = 100;
  localparam int POWERON_DELAY_CYC = (POWERON_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TSTART_REG_CYC = (TSTART_REG_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TPWRT_CYC = (TPWRT_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TRST_CYC = (TRST_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TLOCK_CYC = (TLOCK_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MONITOR_START_DELAY_CYC = (MONITOR_START_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OST_PERIODS = 1024;
  localparam int DLY_W = 23;
  // Register byte offsets
  localparam logic [11:0] OFF_STATUS = 12'h000;
  localparam logic [11:0] OFF_SEQ = 12'h004;
  // Status register bit positions and value after reset
  localparam int B_TRAP = 15;
  localparam int B_ILLOP = 14;
  localparam int B_VREG = 8;
  localparam int B_PIN = 7;
  localparam int B_SOFT = 6;
  localparam int B_WDEN = 5;
  localparam int B_WDOG_TIMEOUT_FLAG = 4;
  localparam int B_SLEEP = 3;
  localparam int B_IDLE = 2;
  localparam int B_BOR = 1;
  localparam int B_POR = 0;
  localparam logic [15:0] STATUS_RST = 16'h0003;
  localparam logic [15:0] STATUS_IMPL = 16'hc1ff;
  // Oscillator source codes
  localparam logic [2:0] OSC_FRC = 3'h0;
  localparam logic [2:0] OSC_FRCPLL = 3'h1;
  localparam logic [2:0] OSC_PRI = 3'h2;
  localparam logic [2:0] OSC_PRIPLL = 3'h3;
  localparam logic [2:0] OSC_SOSC = 3'h4;
  localparam logic [2:0] OSC_LPRC = 3'h5;
  // Sequencer states
  typedef enum logic [3:0] {
    S_HOLD = 4'h1,
    S_CLKWAIT = 4'h2,
    S_RUN = 4'h4,
    S_WAKE = 4'h8
  } seq_state_t;
endpackage

// ===== sim/rst_seq_assertions.sv
`timescale 1ns/10ps
module rst_seq_checker (
  input wire logic pclk, // Bus clock
  input wire logic presetn, // Async reset
  input wire logic psel, // Select
  input wire logic penable, // Enable
  input wire logic pwrite, // Direction
  input wire logic [11:0] paddr, // Address
  input wire logic [31:0] prdata, // Read data
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire logic por_req, // Power-on
  input wire logic bor_req, // Brown-out
  input wire logic soft_reset_req, // Reset instruction
  input wire logic wdog_timeout, // Watchdog
  input wire logic trap_conflict, // Trap conflict
  input wire logic illegal_op, // Illegal op
  input wire logic clock_switch_en, // Switching on
  input wire logic [2:0] config_osc_select, // Configured source
  input wire logic wdog_fuse_enable, // Fuse
  input wire logic clock_fail_monitor_en, // Monitor enable
  input wire logic system_reset_n, // System reset
  input wire logic [2:0] osc_select, // Applied source
  input wire logic clock_released, // Clock given
  input wire logic cpu_run, // Executing
  input wire logic monitor_active, // Monitoring
  input wire logic clock_fail_trap, // Fail trap
  input wire logic wdog_enable // Watchdog on
);
  logic [15:0] lo_cnt_r;
  logic [15:0] hi_cnt_r;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Cycles spent inside and outside system reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lo_cnt_r <= 16'h0;
      hi_cnt_r <= 16'h0;
    end else begin
      lo_cnt_r <= system_reset_n ? 16'h0 : lo_cnt_r + 16'h1;
      hi_cnt_r <= !system_reset_n ? 16'h0 : (&hi_cnt_r ? hi_cnt_r : hi_cnt_r + 16'h1);
    end
  end
  any_event_a: assert property ((por_req | bor_req | soft_reset_req | wdog_timeout |
    trap_conflict | illegal_op) |=> !system_reset_n) else $error("reset not taken");
  trst_min_a: assert property ($rose(system_reset_n) |-> lo_cnt_r >= 16'd800)
    else $error("reset hold too short");
  por_hold_a: assert property (por_req |=> !system_reset_n [*8])
    else $error("power-on hold broken");
  unimpl_zero_a: assert property (psel && penable && !pwrite && paddr == 12'h000
    |-> prdata[13:9] == 5'h00) else $error("unimplemented bits set");
  cpu_gate_a: assert property (cpu_run |-> clock_released && system_reset_n)
    else $error("run without clock");
  wdog_fuse_a: assert property (wdog_fuse_enable |-> wdog_enable)
    else $error("fuse ignored");
  fail_switch_a: assert property (clock_fail_trap |-> ##[0:1] (osc_select == 3'h0
    && clock_released) ##1 !clock_fail_trap) else $error("fallback wrong");
  mon_delay_a: assert property (monitor_active && osc_select inside {3'h1, 3'h3, 3'h4}
    |-> hi_cnt_r >= 16'd3990 && clock_fail_monitor_en) else $error("monitor early");
  fixed_src_a: assert property ($rose(system_reset_n) && !clock_switch_en
    |-> osc_select == config_osc_select) else $error("source not configured");
  bus_err_a: assert property (psel && penable && paddr[11:3] != 9'h0 |-> pready && pslverr)
    else $error("unmapped not refused");
  cover property (soft_reset_req ##1 !system_reset_n);
  cover property (clock_fail_trap);
  cover property ($rose(monitor_active));
endmodule

bind reset_status_and_delay_sequencer rst_seq_checker u_rst_seq_checker (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .por_req(por_req), .bor_req(bor_req),
  .soft_reset_req(soft_reset_req), .wdog_timeout(wdog_timeout), .trap_conflict(trap_conflict),
  .illegal_op(illegal_op), .clock_switch_en(clock_switch_en),
  .config_osc_select(config_osc_select), .wdog_fuse_enable(wdog_fuse_enable),
  .clock_fail_monitor_en(clock_fail_monitor_en), .system_reset_n(system_reset_n),
  .osc_select(osc_select), .clock_released(clock_released), .cpu_run(cpu_run),
  .monitor_active(monitor_active), .clock_fail_trap(clock_fail_trap),
  .wdog_enable(wdog_enable));

// ===== sim/osc_model.sv
`timescale 1ns/10ps
module osc_model (
  input wire logic pclk, // Bus clock
  input wire logic osc_run, // Oscillator powered and swinging
  output logic osc_tick, // Oscillator period
  output logic pll_lock, // PLL locked
  output logic osc_valid // Clock present
);
  logic [2:0] ph_r = 3'h0;
  // Six bus cycles per period, slower than the sync limit; stands still when stopped
  always_ff @(posedge pclk) begin
    ph_r <= (!osc_run || ph_r == 3'h5) ? 3'h0 : ph_r + 3'h1;
  end
  assign osc_tick = osc_run && ph_r >= 3'h3;
  assign pll_lock = osc_run;
  assign osc_valid = osc_run;
endmodule

// ===== sim/testbench.sv
`timescale 1ns/10ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin err_count++; \
  $display("Error %s exp %h got %h", nm, e, g); end end
module testbench;
  logic pclk, presetn, psel, penable, pwrite, pin_n, reg_en, sw_en, fuse, osc_run, er, wk;
  logic pready, pslverr, osc_tick, pll_lock, osc_valid, system_reset_n, clock_released;
  logic cpu_run, monitor_active, clock_fail_trap, wdog_enable, regulator_sleep_keep;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] ev;
  logic [2:0] cfg, cur, osc_select;
  int err_count, total_checks, cyc, n;
  reset_status_and_delay_sequencer #(.POWERUP_TIMER_CYCLES(50)) u_reset_status_and_delay_sequencer (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'h3), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .por_req(ev[0]), .bor_req(ev[1]), .pin_master_clear_n(pin_n),
    .soft_reset_req(ev[2]), .wdog_timeout(ev[3]), .trap_conflict(ev[4]), .illegal_op(ev[5]),
    .power_save_sleep(ev[6]), .power_save_idle(ev[7]), .wake_req(wk), .regulator_en(reg_en),
    .clock_switch_en(sw_en), .config_osc_select(cfg), .current_osc_select(cur),
    .primary_is_crystal(1'b1), .wdog_fuse_enable(fuse), .clock_fail_monitor_en(1'b1),
    .osc_tick(osc_tick), .pll_lock(pll_lock), .osc_valid(osc_valid),
    .system_reset_n(system_reset_n), .osc_select(osc_select), .clock_released(clock_released),
    .cpu_run(cpu_run), .monitor_active(monitor_active), .clock_fail_trap(clock_fail_trap),
    .wdog_enable(wdog_enable), .regulator_sleep_keep(regulator_sleep_keep));
  osc_model u_osc_model (.pclk(pclk), .osc_run(osc_run), .osc_tick(osc_tick),
    .pll_lock(pll_lock), .osc_valid(osc_valid));
  // Clock at 40 MHz
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // Hang guard
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 60000) begin
      err_count++;
      complete_run();
    end
  end
  task automatic complete_run();
    if (err_count == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // One bus transfer, held until ready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // One-cycle event pulse
  task automatic pulse(input logic [7:0] m);
    @(posedge pclk);
    ev <= m;
    @(posedge pclk);
    ev <= 8'h00;
  endtask
  // Cycles until system reset releases
  task automatic hold();
    n = 0;
    #1;
    while (system_reset_n !== 1'b1 && n < 9000) begin
      @(posedge pclk);
      #1;
      n++;
    end
  endtask
  function automatic logic win(input int v, input int lo, input int hi);
    return v >= lo && v <= hi;
  endfunction
  task automatic t_soft();
    pulse(8'h04);
    hold();
    `CHK("soft hold", 1'b1, win(n, 798, 803))
    `CHK("soft source", 3'h5, osc_select)
    apb(1'b0, 12'h000, 32'h0);
    `CHK("soft flags", 16'h0043, rd[15:0])
  endtask
  task automatic t_pin();
    @(posedge pclk);
    pin_n <= 1'b0;
    repeat (6) @(posedge pclk);
    pin_n <= 1'b1;
    hold();
    `CHK("pin hold", 1'b1, win(n, 798, 820))
    apb(1'b0, 12'h000, 32'h0);
    `CHK("pin flags", 16'h00c3, rd[15:0])
  endtask
  task automatic t_flags();
    pulse(8'h38);
    hold();
    `CHK("fault hold", 1'b1, win(n, 798, 803))
    apb(1'b0, 12'h000, 32'h0);
    `CHK("fault flags", 16'hc0d3, rd[15:0])
    pulse(8'h40);
    apb(1'b0, 12'h000, 32'h0);
    `CHK("sleep flags", 16'hc0cb, rd[15:0])
    pulse(8'h80);
    apb(1'b0, 12'h000, 32'h0);
    `CHK("idle flags", 16'hc0cf, rd[15:0])
    pulse(8'h02);
    hold();
    `CHK("bor hold", 1'b1, win(n, 848, 853))
    `CHK("bor source", 3'h0, osc_select)
    apb(1'b0, 12'h000, 32'h0);
    `CHK("bor flags", 16'h0083, rd[15:0])
    reg_en <= 1'b1;
    pulse(8'h01);
    hold();
    `CHK("por hold", 1'b1, win(n, 1998, 2003))
    apb(1'b0, 12'h000, 32'h0);
    `CHK("por flags", 16'h0003, rd[15:0])
  endtask
  task automatic t_apb();
    apb(1'b1, 12'h000, 32'h0000ffff);
    apb(1'b0, 12'h000, 32'h0);
    `CHK("all ones", 16'hc1ff, rd[15:0])
    `CHK("no reset", 1'b1, system_reset_n)
    `CHK("reg keep", 1'b1, regulator_sleep_keep)
    `CHK("wd soft", 1'b1, wdog_enable)
    apb(1'b1, 12'h000, 32'h0);
    apb(1'b0, 12'h000, 32'h0);
    `CHK("all zero", 16'h0000, rd[15:0])
    `CHK("wd off", 1'b0, wdog_enable)
    fuse <= 1'b1;
    @(posedge pclk);
    #1;
    `CHK("wd fuse", 1'b1, wdog_enable)
    apb(1'b0, 12'h010, 32'h0);
    `CHK("unmapped", 1'b1, er)
  endtask
  task automatic t_xtal();
    sw_en <= 1'b0;
    cfg <= 3'h2;
    pulse(8'h04);
    hold();
    `CHK("fixed source", 3'h2, osc_select)
    `CHK("ost wait", 1'b0, clock_released)
    `CHK("no run", 1'b0, cpu_run)
    n = 0;
    while (clock_released !== 1'b1 && n < 9000) begin
      @(posedge pclk);
      #1;
      n++;
    end
    `CHK("ost length", 1'b1, win(n, 4000, 6000))
    repeat (3) @(posedge pclk);
    #1;
    `CHK("run", 1'b1, cpu_run)
  endtask
  task automatic t_fail();
    cfg <= 3'h3;
    osc_run <= 1'b0;
    pulse(8'h04);
    hold();
    n = 0;
    while (clock_fail_trap !== 1'b1 && n < 5000) begin
      @(posedge pclk);
      #1;
      n++;
    end
    `CHK("monitor delay", 1'b1, win(n, 3990, 4010))
    `CHK("fallback src", 3'h0, osc_select)
    @(posedge pclk);
    #1;
    `CHK("fallback clk", 1'b1, clock_released)
    osc_run <= 1'b1;
  endtask
  // Regulated wake holds code execution for the start-up delay only
  task automatic t_wake();
    @(posedge pclk);
    wk <= 1'b1;
    @(posedge pclk);
    wk <= 1'b0;
    #1;
    `CHK("wake hold", 1'b0, cpu_run)
    `CHK("wake no reset", 1'b1, system_reset_n)
    n = 0;
    while (cpu_run !== 1'b1 && n < 2000) begin
      @(posedge pclk);
      #1;
      n++;
    end
    `CHK("wake length", 1'b1, win(n, 798, 803))
  endtask
  // Crystal with PLL: start-up count, then lock time, before clock release
  task automatic t_pll();
    pulse(8'h04);
    hold();
    `CHK("pll source", 3'h3, osc_select)
    `CHK("pll wait", 1'b0, clock_released)
    n = 0;
    while (clock_released !== 1'b1 && n < 9000) begin
      @(posedge pclk);
      #1;
      n++;
    end
    `CHK("pll length", 1'b1, win(n, 6130, 6160))
    repeat (2) @(posedge pclk);
    #1;
    `CHK("pll run", 1'b1, cpu_run)
  endtask
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, reg_en, fuse, er, wk} = 7'h00;
    {pin_n, sw_en, osc_run} = 3'h7;
    paddr = 12'h000;
    pwdata = 32'h0;
    ev = 8'h00;
    cfg = 3'h0;
    cur = 3'h5;
    {err_count, total_checks, cyc} = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    hold();
    `CHK("init hold", 1'b1, win(n, 1248, 1253))
    apb(1'b0, 12'h000, 32'h0);
    `CHK("init flags", 16'h0003, rd[15:0])
    t_soft();
    t_pin();
    t_flags();
    t_apb();
    t_wake();
    t_xtal();
    t_fail();
    t_pll();
    complete_run();
  end
endmodule
